// >>> logic/adc_parallel_host_port.sv
/*
   Device side of the converter's parallel processor port: select decode,
   programmable strobes, two control registers, result pipeline, channel
   marker and an Avalon-MM slave for sample feed and status.
   Assumes every port pin arrives asynchronously and the bench resolves the
   shared data bus from o_data_bus_oe.
*/
`timescale 1ns/100ps
module adc_parallel_host_port (
   input  wire logic        i_clock,
   input  wire logic        i_rst_b,
   input  wire logic        i_clk_en,
   input  wire logic        i_conversion_clock,
   input  wire logic        i_select_active_low_n,
   input  wire logic        i_select_active_high,
   input  wire logic        i_wr_strobe,
   input  wire logic        i_rd_strobe_n,
   input  wire logic        i_reg_addr_bit0,
   input  wire logic        i_reg_addr_bit1,
   input  wire logic        i_hw_reset,
   input  wire logic [9:0]  i_data_bus_in,
   output logic      [9:0]  o_data_bus_out,
   output logic             o_data_bus_oe,
   output logic             o_marker_n,
   output logic             o_ref_external,
   input  wire logic [3:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest
);

   typedef struct packed {
      logic [adc_port_pkg::SYNC_W-1:0]  sync1;
      logic [adc_port_pkg::SYNC_W-1:0]  sync2;
      logic                             conv_prev;
      logic                             wr_prev;
      logic [adc_port_pkg::DATA_W-1:0]  wr_data;
      logic [1:0]                       wr_addr;
      logic [adc_port_pkg::DATA_W-1:0]  cr0;
      logic [adc_port_pkg::DATA_W-1:0]  cr1;
      logic [adc_port_pkg::DATA_W-1:0]  sample_a;
      logic [adc_port_pkg::DATA_W-1:0]  sample_b;
      logic                             chan_b;
      logic [adc_port_pkg::PIPE_AW-1:0] wptr;
      logic [adc_port_pkg::PIPE_AW-1:0] primed;
      logic [adc_port_pkg::HOLD_W-1:0]  hold;
      logic                             pend;
      logic                             pend_ok;
      logic [adc_port_pkg::DATA_W-1:0]  data_out;
      logic                             data_oe;
      logic                             marker_n;
      logic                             ref_ext;
      logic                             avs_wait;
      logic [31:0]                      avs_rdata;
   } port_state_t;

   port_state_t                       state_q;
   port_state_t                       state_d;
   logic                              conv_fall;
   logic                              sel;
   logic                              wr_only;
   logic                              two_ch;
   logic                              wr_act;
   logic                              rd_act;
   logic                              wr_end;
   logic                              mark_rst;
   logic                              hw_rst;
   logic [adc_port_pkg::PIPE_W-1:0]   pipe_rd;
   logic [adc_port_pkg::PIPE_AW-1:0]  pipe_raddr;
   logic [31:0]                       status;

   // ****************************************************************
   // Result pipeline memory
   // ****************************************************************
   result_pipe #(
      .WIDTH  (adc_port_pkg::PIPE_W),
      .ADDR_W (adc_port_pkg::PIPE_AW)
   ) u_pipe (
      .i_clock   (i_clock),
      .i_rst_b   (i_rst_b),
      .i_clk_en  (i_clk_en),
      .i_wr_en   (conv_fall),
      .i_wr_addr (state_q.wptr),
      .i_wr_data ({~state_q.chan_b, state_q.chan_b ? state_q.sample_b : state_q.sample_a}),
      .i_rd_en   (conv_fall),
      .i_rd_addr (pipe_raddr),
      .o_rd_data (pipe_rd)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      state_d = state_q;
      state_d.sync1 = {i_hw_reset, i_data_bus_in, i_reg_addr_bit1, i_reg_addr_bit0,
                       i_rd_strobe_n, i_wr_strobe, i_select_active_high,
                       i_select_active_low_n, i_conversion_clock};
      state_d.sync2 = state_q.sync1;
      conv_fall = state_q.conv_prev & ~state_q.sync2[adc_port_pkg::PIN_CONV];
      state_d.conv_prev = state_q.sync2[adc_port_pkg::PIN_CONV];
      hw_rst  = state_q.sync2[adc_port_pkg::PIN_HWRST];
      sel     = ~state_q.sync2[adc_port_pkg::PIN_SEL_N]
                & state_q.sync2[adc_port_pkg::PIN_SEL];
      wr_only = state_q.cr1[adc_port_pkg::CR1_WR_ONLY_BIT];
      two_ch  = state_q.cr1[adc_port_pkg::CR1_TWO_CH_BIT];
      wr_act  = sel & ~state_q.sync2[adc_port_pkg::PIN_WR];
      rd_act  = sel & (wr_only ? ~state_q.sync2[adc_port_pkg::PIN_RD_N]
                               : state_q.sync2[adc_port_pkg::PIN_WR]) & ~wr_act;
      wr_end  = state_q.wr_prev & ~wr_act;
      state_d.wr_prev = wr_act;
      mark_rst = 1'b0;
      pipe_raddr = state_q.wptr - adc_port_pkg::PIPE_LATENCY;
      if (wr_act)
      begin
         state_d.wr_data = state_q.sync2[adc_port_pkg::PIN_DATA +: adc_port_pkg::DATA_W];
         state_d.wr_addr = state_q.sync2[adc_port_pkg::PIN_RA1 -: 2];
      end
      if (wr_end)
      begin
         case (state_q.wr_addr)
            adc_port_pkg::REG_ADDR_CR0:
            begin
               state_d.cr0 = state_q.wr_data;
            end
            adc_port_pkg::REG_ADDR_CR1:
            begin
               state_d.cr1 = state_q.wr_data;
               state_d.cr1[adc_port_pkg::CR1_MARK_RST_BIT] = 1'b0;
               mark_rst = state_q.wr_data[adc_port_pkg::CR1_MARK_RST_BIT];
            end
            default: mark_rst = 1'b0;
         endcase
      end
      state_d.data_oe = rd_act;
      state_d.ref_ext = state_q.cr0[adc_port_pkg::CR0_REF_EXT_BIT];
      if (conv_fall)
      begin
         state_d.wptr    = state_q.wptr + 3'h1;
         state_d.chan_b  = two_ch & ~state_q.chan_b;
         state_d.pend    = 1'b1;
         state_d.pend_ok = (state_q.primed == adc_port_pkg::PIPE_LATENCY);
         if (state_q.primed != adc_port_pkg::PIPE_LATENCY)
         begin
            state_d.primed = state_q.primed + 3'h1;
         end
         if (state_q.hold != '0)
         begin
            state_d.hold = state_q.hold - 4'h1;
         end
      end
      if (state_q.pend)
      begin
         state_d.pend = 1'b0;
         if (state_q.pend_ok)
         begin
            state_d.data_out = pipe_rd[adc_port_pkg::DATA_W-1:0]
                               ^ (state_q.cr1[adc_port_pkg::CR1_TWOS_BIT] ?
                                  adc_port_pkg::TWOS_FLIP : 10'h000);
            state_d.marker_n = ~(pipe_rd[adc_port_pkg::DATA_W] & (state_q.hold == '0));
         end
         else
         begin
            state_d.data_out = '0;
            state_d.marker_n = 1'b1;
         end
      end
      if (hw_rst)
      begin
         state_d.cr0 = adc_port_pkg::CR0_RESET;
         state_d.cr1 = adc_port_pkg::CR1_RESET;
      end
      if (mark_rst || hw_rst)
      begin
         state_d.hold     = adc_port_pkg::MARK_HOLD_BASE
                            + (state_d.cr1[adc_port_pkg::CR1_TWO_CH_BIT] ?
                               adc_port_pkg::CH_TWO : adc_port_pkg::CH_ONE);
         state_d.chan_b   = 1'b0;
         state_d.marker_n = 1'b1;
      end
      if (!two_ch || !state_d.cr1[adc_port_pkg::CR1_TWO_CH_BIT])
      begin
         state_d.marker_n = 1'b1;
      end
      status = '0;
      status[adc_port_pkg::DATA_W-1:0] = state_q.cr1;
      status[adc_port_pkg::STAT_MARKER_BIT] = state_q.marker_n;
      status[adc_port_pkg::STAT_PRIMED_BIT] = (state_q.primed == adc_port_pkg::PIPE_LATENCY);
      state_d.avs_wait = 1'b1;
      if ((i_avs_read || i_avs_write) && state_q.avs_wait)
      begin
         state_d.avs_wait = 1'b0;
         case (i_avs_address)
            adc_port_pkg::AVS_SAMPLE_A: state_d.avs_rdata = {22'h0, state_q.sample_a};
            adc_port_pkg::AVS_SAMPLE_B: state_d.avs_rdata = {22'h0, state_q.sample_b};
            adc_port_pkg::AVS_CR0:      state_d.avs_rdata = {22'h0, state_q.cr0};
            adc_port_pkg::AVS_STATUS:   state_d.avs_rdata = status;
            default:                    state_d.avs_rdata = 32'h0;
         endcase
      end
      if (i_avs_write && !state_q.avs_wait)
      begin
         if (i_avs_address == adc_port_pkg::AVS_SAMPLE_A)
         begin
            if (i_avs_byteenable[0]) state_d.sample_a[7:0] = i_avs_writedata[7:0];
            if (i_avs_byteenable[1]) state_d.sample_a[9:8] = i_avs_writedata[9:8];
         end
         if (i_avs_address == adc_port_pkg::AVS_SAMPLE_B)
         begin
            if (i_avs_byteenable[0]) state_d.sample_b[7:0] = i_avs_writedata[7:0];
            if (i_avs_byteenable[1]) state_d.sample_b[9:8] = i_avs_writedata[9:8];
         end
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_q          <= '0;
         state_q.cr0      <= adc_port_pkg::CR0_RESET;
         state_q.cr1      <= adc_port_pkg::CR1_RESET;
         state_q.hold     <= adc_port_pkg::MARK_HOLD_BASE + adc_port_pkg::CH_ONE;
         state_q.marker_n <= 1'b1;
         state_q.avs_wait <= 1'b1;
      end
      else if (i_clk_en)
      begin
         state_q <= state_d;
      end
   end

   assign o_data_bus_out    = state_q.data_out;
   assign o_data_bus_oe     = state_q.data_oe;
   assign o_marker_n        = state_q.marker_n;
   assign o_ref_external    = state_q.ref_ext;
   assign o_avs_readdata    = state_q.avs_rdata;
   assign o_avs_waitrequest = state_q.avs_wait;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);

   select_gate_a: assert property (i_clk_en && !sel |=> !o_data_bus_oe)
      else $error("bus driven while not selected");
   read_drive_a: assert property (i_clk_en && rd_act |=> o_data_bus_oe)
      else $error("selected read did not drive bus");
   rd_ignored_a: assert property (i_clk_en && !wr_only && sel
                                  && !state_q.sync2[adc_port_pkg::PIN_WR]
                                  |=> !o_data_bus_oe)
      else $error("read strobe honoured in read/write mode");
   cr0_write_a: assert property (i_clk_en && wr_end && !hw_rst
                                 && state_q.wr_addr == adc_port_pkg::REG_ADDR_CR0
                                 |=> state_q.cr0 == $past(state_q.wr_data))
      else $error("control register zero not written");
   hw_reset_a: assert property (i_clk_en && hw_rst |=> state_q.cr0 == adc_port_pkg::CR0_RESET
                                && state_q.cr1 == adc_port_pkg::CR1_RESET)
      else $error("hardware reset missed defaults");
   ref_sel_a: assert property (i_clk_en ##1 i_clk_en |->
                               o_ref_external == $past(state_q.cr0[0]))
      else $error("reference select does not follow register");
   single_mark_a: assert property (i_clk_en && !two_ch |=> o_marker_n)
      else $error("marker active with one input");
   mark_hold_a: assert property (i_clk_en && mark_rst && !hw_rst
                                 && state_q.wr_data[adc_port_pkg::CR1_TWO_CH_BIT]
                                 |=> state_q.hold == 4'h9 && o_marker_n)
      else $error("marker hold not loaded");
   withheld_a: assert property (!o_marker_n |-> state_q.hold == '0 && two_ch)
      else $error("marker low while withheld");
   conv_step_a: assert property (i_clk_en && conv_fall |=>
                                 state_q.wptr == $past(state_q.wptr) + 3'h1)
      else $error("conversion not started on clock fall");
   avs_ack_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest && i_clk_en
                               |=> !o_avs_waitrequest)
      else $error("bus slave did not answer");

   read_seen_c:  cover property (rd_act ##1 o_data_bus_oe);
   cr1_write_c:  cover property (wr_end && state_q.wr_addr == adc_port_pkg::REG_ADDR_CR1);
   marker_low_c: cover property (!o_marker_n);
   avs_write_c:  cover property (i_avs_write && !o_avs_waitrequest);

endmodule

// >>> logic/adc_port_pkg.sv
/*
   Shared constants of the converter's parallel host port: pin sampling
   positions, control register fields and reset values, pipeline timing
   and the software register map.
   Assumes a single 100 MHz clock domain for every user of the package.
*/
package adc_port_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int unsigned DATA_W   = 10;
   localparam int unsigned PIPE_AW  = 3;
   localparam int unsigned PIPE_W   = DATA_W + 1;
   localparam int unsigned HOLD_W   = 4;
   localparam int unsigned SYNC_W   = 18;

   // ****************************************************************
   // Pin positions in the synchroniser vector
   // ****************************************************************
   localparam int unsigned PIN_CONV   = 0;
   localparam int unsigned PIN_SEL_N  = 1;
   localparam int unsigned PIN_SEL    = 2;
   localparam int unsigned PIN_WR     = 3;
   localparam int unsigned PIN_RD_N   = 4;
   localparam int unsigned PIN_RA0    = 5;
   localparam int unsigned PIN_RA1    = 6;
   localparam int unsigned PIN_DATA   = 7;
   localparam int unsigned PIN_HWRST  = 17;

   // ****************************************************************
   // Control registers
   // ****************************************************************
   localparam logic [1:0]        REG_ADDR_CR0      = 2'h0;
   localparam logic [1:0]        REG_ADDR_CR1      = 2'h1;
   localparam int unsigned       CR0_REF_EXT_BIT   = 0;
   localparam int unsigned       CR1_WR_ONLY_BIT   = 0;
   localparam int unsigned       CR1_TWO_CH_BIT    = 1;
   localparam int unsigned       CR1_MARK_RST_BIT  = 2;
   localparam int unsigned       CR1_TWOS_BIT      = 3;
   localparam logic [DATA_W-1:0] CR0_RESET         = 10'h000;
   localparam logic [DATA_W-1:0] CR1_RESET         = 10'h000;
   localparam logic [DATA_W-1:0] TWOS_FLIP         = 10'h200;

   // ****************************************************************
   // Conversion timing, in conversion clock cycles
   // ****************************************************************
   localparam logic [PIPE_AW-1:0] PIPE_LATENCY    = 3'h5;
   localparam logic [HOLD_W-1:0]  MARK_HOLD_BASE  = 4'h7;
   localparam logic [HOLD_W-1:0]  CH_ONE          = 4'h1;
   localparam logic [HOLD_W-1:0]  CH_TWO          = 4'h2;

   // ****************************************************************
   // Software register map, byte offsets and status bit positions
   // ****************************************************************
   localparam logic [3:0]  AVS_SAMPLE_A    = 4'h0;
   localparam logic [3:0]  AVS_SAMPLE_B    = 4'h4;
   localparam logic [3:0]  AVS_CR0         = 4'h8;
   localparam logic [3:0]  AVS_STATUS      = 4'hc;
   localparam int unsigned STAT_MARKER_BIT = 16;
   localparam int unsigned STAT_PRIMED_BIT = 17;

endpackage

// >>> logic/result_pipe.sv
/*
   Small result memory that models the conversion pipeline: one entry per
   conversion, read back a fixed distance behind the write pointer.
   Assumes the caller supplies addresses and keeps the distance below DEPTH.
*/
`timescale 1ns/100ps
module result_pipe #(
   parameter int unsigned WIDTH  = 11,
   parameter int unsigned ADDR_W = 3
) (
   input  wire logic              i_clock,
   input  wire logic              i_rst_b,
   input  wire logic              i_clk_en,
   input  wire logic              i_wr_en,
   input  wire logic [ADDR_W-1:0] i_wr_addr,
   input  wire logic [WIDTH-1:0]  i_wr_data,
   input  wire logic              i_rd_en,
   input  wire logic [ADDR_W-1:0] i_rd_addr,
   output logic      [WIDTH-1:0]  o_rd_data
);

   typedef struct packed {
      logic [WIDTH-1:0] rd_data;
   } pipe_state_t;

   logic [WIDTH-1:0] mem_q [2**ADDR_W];
   pipe_state_t      state_q;
   pipe_state_t      state_d;

   // ****************************************************************
   // Storage
   // ****************************************************************
   always_ff @(posedge i_clock)
   begin
      if (i_clk_en && i_wr_en)
      begin
         mem_q[i_wr_addr] <= i_wr_data;
      end
   end

   always_comb
   begin
      state_d = state_q;
      if (i_rd_en)
      begin
         state_d.rd_data = mem_q[i_rd_addr];
      end
   end

   always_ff @(posedge i_clock or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_q <= '0;
      end
      else if (i_clk_en)
      begin
         state_q <= state_d;
      end
   end

   assign o_rd_data = state_q.rd_data;

endmodule

// >>> bench/proc_bus_model.sv
/*
   Processor bus master model for the parallel host port: conversion
   clock, selects, strobes, address lines and its half of the data bus.
   Assumes its tasks are called from one bench process on i_clock.
*/
`timescale 1ns/100ps
module proc_bus_model (
   input  wire logic       i_clock,
   input  wire logic [9:0] i_dev_data,
   input  wire logic       i_dev_oe,
   output logic            o_conversion_clock,
   output logic            o_sel_n,
   output logic            o_sel,
   output logic            o_wr,
   output logic            o_rd_n,
   output logic [1:0]      o_addr,
   output logic [9:0]      o_bus
);
   // ****************************************
   // Pins and data bus
   // ****************************************
   logic       drv = 1'b0;
   logic [9:0] wdata = 10'h000;
   logic [9:0] last = 10'h000;
   logic [3:0] div = 4'h0;

   initial
   begin
      o_sel_n = 1'b1;
      o_sel = 1'b0;
      o_wr = 1'b1;
      o_rd_n = 1'b1;
      o_addr = 2'h0;
   end

   // Free running, sixteen system clocks per period
   always @(posedge i_clock)
   begin
      div <= div + 4'h1;
      o_conversion_clock <= ~div[3];
   end

   // Released bus shows the inverse of its last driven value
   assign o_bus = i_dev_oe ? i_dev_data : (drv ? wdata : ~last);

   always @(posedge i_clock)
      if (i_dev_oe || drv)
         last <= o_bus;

   task automatic par_write(input logic [1:0] a, input logic [9:0] d,
                            input logic s_n, input logic s);
      @(posedge i_clock);
      o_sel_n <= s_n;
      o_sel <= s;
      o_addr <= a;
      wdata <= d;
      drv <= 1'b1;
      o_wr <= 1'b0;
      repeat (4) @(posedge i_clock);
      o_sel_n <= 1'b1;
      o_sel <= 1'b0;
      o_wr <= 1'b1;
      @(posedge i_clock);
      drv <= 1'b0;
      repeat (5) @(posedge i_clock);
   endtask

   task automatic set_read(input logic s, input logic rd);
      @(posedge i_clock);
      o_sel_n <= ~s;
      o_sel <= s;
      o_wr <= 1'b1;
      o_rd_n <= ~rd;
      repeat (5) @(posedge i_clock);
   endtask
endmodule

// >>> bench/adc_parallel_host_port_tb_top.sv
/*
   Self-checking bench of the parallel host port: Avalon accesses from
   the bench, processor pin traffic from the bus master model.
   Assumes the design and the bus master model are compiled first.
*/
`timescale 1ns/100ps
`define CHK(what, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         bad_count++; \
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got); \
      end \
   end
module adc_parallel_host_port_tb_top;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic        i_clock = 1'b0;
   logic        i_rst_b = 1'b0;
   logic        hw_rst = 1'b0;
   logic [3:0]  address = 4'h0;
   logic        rd = 1'b0;
   logic        wr_en = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rq;
   int          bad_count = 0;
   int          n_compared = 0;
   int          lows = 0;
   wire         conv, sel_n, sel, wr, rd_n, oe, marker_n, ref_ext, waitreq;
   wire  [1:0]  ra;
   wire  [9:0]  bus, dout;
   wire  [31:0] rdata;

   adc_parallel_host_port DUT (
      .i_clock               (i_clock),
      .i_rst_b               (i_rst_b),
      .i_clk_en              (1'b1),
      .i_conversion_clock    (conv),
      .i_select_active_low_n (sel_n),
      .i_select_active_high  (sel),
      .i_wr_strobe           (wr),
      .i_rd_strobe_n         (rd_n),
      .i_reg_addr_bit0       (ra[0]),
      .i_reg_addr_bit1       (ra[1]),
      .i_hw_reset            (hw_rst),
      .i_data_bus_in         (bus),
      .o_data_bus_out        (dout),
      .o_data_bus_oe         (oe),
      .o_marker_n            (marker_n),
      .o_ref_external        (ref_ext),
      .i_avs_address         (address),
      .i_avs_read            (rd),
      .i_avs_write           (wr_en),
      .i_avs_writedata       (wdat),
      .i_avs_byteenable      (4'hf),
      .o_avs_readdata        (rdata),
      .o_avs_waitrequest     (waitreq)
   );

   proc_bus_model host (
      .i_clock    (i_clock),
      .i_dev_data (dout),
      .i_dev_oe   (oe),
      .o_conversion_clock (conv),
      .o_sel_n    (sel_n),
      .o_sel      (sel),
      .o_wr       (wr),
      .o_rd_n     (rd_n),
      .o_addr     (ra),
      .o_bus      (bus)
   );

   always #5 i_clock = ~i_clock;

   // ****************************************
   // Tasks
   // ****************************************
   task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clock);
      address <= a;
      wr_en <= w;
      rd <= ~w;
      wdat <= d;
      @(posedge i_clock);
      while (waitreq !== 1'b0)
         @(posedge i_clock);
      rq = rdata;
      wr_en <= 1'b0;
      rd <= 1'b0;
   endtask

   task automatic wait_fall();
      @(negedge conv);
      repeat (6) @(posedge i_clock);
   endtask

   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge i_clock);
      bad_count++;
      end_of_test();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial
   begin
      repeat (16) @(posedge i_clock);
      i_rst_b <= 1'b1;
      repeat (2) @(posedge i_clock);
      `CHK("oe", 1'b0, oe);
      `CHK("marker", 1'b1, marker_n);
      `CHK("ref", 1'b0, ref_ext);
      host.par_write(2'h1, 10'h000, 1'b0, 1'b1);
      host.par_write(2'h0, 10'h001, 1'b0, 1'b1);
      `CHK("ref", 1'b1, ref_ext);
      host.par_write(2'h2, 10'h000, 1'b0, 1'b1);
      host.par_write(2'h0, 10'h000, 1'b1, 1'b1);
      host.par_write(2'h0, 10'h000, 1'b0, 1'b0);
      avs(1'b1, 4'h8, 32'h0);
      avs(1'b0, 4'h8, 32'h0);
      `CHK("cr0", 10'h001, rq[9:0]);
      avs(1'b0, 4'hc, 32'h0);
      `CHK("cr1", 10'h000, rq[9:0]);
      avs(1'b0, 4'h2, 32'h0);
      `CHK("unmapped", 32'h0, rq);
      avs(1'b1, 4'h0, 32'h155);
      avs(1'b0, 4'h0, 32'h0);
      `CHK("sample_a", 10'h155, rq[9:0]);
      repeat (6) wait_fall();
      host.set_read(1'b1, 1'b0);
      `CHK("oe", 1'b1, oe);
      `CHK("bus", 10'h155, bus);
      `CHK("marker", 1'b1, marker_n);
      wait_fall();
      avs(1'b1, 4'h0, 32'h2aa);
      for (int k = 1; k <= 6; k++)
      begin
         wait_fall();
         `CHK("bus", (k == 6) ? 10'h2aa : 10'h155, bus);
      end
      host.set_read(1'b0, 1'b0);
      `CHK("oe", 1'b0, oe);
      host.par_write(2'h1, 10'h001, 1'b0, 1'b1);
      host.set_read(1'b1, 1'b0);
      `CHK("oe", 1'b0, oe);
      host.set_read(1'b1, 1'b1);
      `CHK("oe", 1'b1, oe);
      host.set_read(1'b0, 1'b0);
      avs(1'b1, 4'h0, 32'h011);
      avs(1'b1, 4'h4, 32'h022);
      host.par_write(2'h1, 10'h006, 1'b0, 1'b1);
      for (int k = 0; k < 7; k++)
      begin
         wait_fall();
         `CHK("marker", 1'b1, marker_n);
      end
      repeat (3) wait_fall();
      for (int k = 0; k < 12; k++)
      begin
         wait_fall();
         `CHK("marker", dout !== 10'h011, marker_n);
         lows += (marker_n === 1'b0);
      end
      `CHK("lows", 6, lows);
      avs(1'b0, 4'hc, 32'h0);
      `CHK("cr1", 10'h002, rq[9:0]);
      hw_rst <= 1'b1;
      repeat (4) @(posedge i_clock);
      hw_rst <= 1'b0;
      repeat (6) @(posedge i_clock);
      `CHK("ref", 1'b0, ref_ext);
      avs(1'b0, 4'hc, 32'h0);
      `CHK("cr1", 10'h000, rq[9:0]);
      `CHK("marker", 1'b1, marker_n);
      host.par_write(2'h1, 10'h008, 1'b0, 1'b1);
      host.set_read(1'b1, 1'b0);
      repeat (6) wait_fall();
      `CHK("twos", 10'h011 ^ adc_port_pkg::TWOS_FLIP, bus);
      end_of_test();
   end
endmodule
